// ===== rtl/spr_regs.svh
`ifndef SPR_REGS_SVH
`define SPR_REGS_SVH

// register byte offsets on the APB side
`define SPR_CTRL_OFS       12'h000
`define SPR_STATUS_OFS     12'h004
`define SPR_DEST_LATCH_OFS 12'h008
`define SPR_SRC_LATCH_OFS  12'h00C
`define SPR_TEMP_LATCH_OFS 12'h010

// control register fields and reset value
`define SPR_CTRL_PTR_DOWN_BIT 0
`define SPR_CTRL_RESET        32'h0000_0000

// status register field positions
`define SPR_STAT_EMPTY_BIT 0
`define SPR_STAT_PTR_LSB   4
`define SPR_STAT_PC_LSB    8

// fixed scratchpad opcodes
`define SPR_OP_TEMP_LOAD_SH  7'h06
`define SPR_OP_TEMP_WRITE_SH 7'h07

// undo log entry layout
`define SPR_LOG_ADD_BIT   8
`define SPR_LOG_CONST_LSB 4
`define SPR_LOG_ADDR_LSB  0

`endif

// ===== rtl/spr_pkg.sv
package spr_pkg;

   // width of a general-register write
   typedef enum logic [1:0] {
      SPR_DT_LONG   = 2'h0,
      SPR_DT_WORD   = 2'h1,
      SPR_DT_BYTE   = 2'h2,
      SPR_DT_DECODE = 2'h3
   } spr_dt_t;

   // write notification code sent to the float accelerator
   typedef enum logic [1:0] {
      SPR_FW_WORD  = 2'h0,
      SPR_FW_LONG  = 2'h1,
      SPR_FW_BYTE  = 2'h2,
      SPR_FW_NONE  = 2'h3
   } spr_fw_t;

   // microword fields driving the block
   typedef struct packed {
      logic [6:0] scratchpad_opcode_field;
      spr_dt_t    data_type_select;
      logic       log_update;   // alu_function_field asks for a log entry
      logic       log_add;      // that alu function is an add
      logic       log_read;     // misc_control_field asks for a log read
      logic       instr_fetch;  // an instruction is being fetched
   } spr_uword_t;

   // instruction context from decode and the shift-count register
   typedef struct packed {
      logic       compat_mode;
      logic       float_ctx;
      spr_dt_t    decode_dt;
      logic [3:0] shift_count_reg;
      logic [3:0] spec_one_reg_field;
      logic [3:0] spec_two_reg_field;
      logic [3:0] previous_spec_reg;
      logic [3:0] compat_source_reg;
      logic [3:0] compat_dest_reg;
      logic [3:0] constant_mux;
      logic [7:0] pc_low;
   } spr_ctx_t;

   // notification to the float accelerator
   typedef struct packed {
      logic [3:0] addr;
      spr_fw_t    we_code;
   } spr_fac_t;

endpackage

// ===== rtl/spr_scratchpad.sv
`timescale 1ns/1ps
`include "spr_regs.svh"

module spr_scratchpad
   import spr_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire spr_uword_t  uword,
   input  wire spr_ctx_t    ctx,
   input  wire logic [31:0] wr_data,
   output logic      [31:0] dest_port_latch,
   output logic      [31:0] src_port_latch,
   output logic      [31:0] temp_read_latch,
   output spr_fac_t         float_accelerator,
   output logic      [8:0]  reg_undo_log,
   output logic             log_empty,
   output logic      [7:0]  pc_low_save
);

   logic [31:0] gen_bank  [16];   // shared by dest_port_bank and src_port_bank
   logic [31:0] temp_bank [16];
   logic [8:0]  undo_mem  [16];

   logic [31:0] ctrl_reg;
   logic [3:0]  log_ptr_reg;
   logic [31:0] prdata_reg;
   logic        pready_reg;
   logic        pslverr_reg;

   // opcode field split
   // the seven bits carry a group in 6:4 and a register or code below;
   // bit 3 splits the two low groups into halves (00-07 fixed codes, 08-0F and 10-17 loads, 18-1F writes), while
   // the upper groups use all four low bits as a register number
   wire logic [6:0] op       = uword.scratchpad_opcode_field;
   wire logic [2:0] op_grp   = op[6:4];
   wire logic       op_hi    = op[3];
   wire logic [3:0] reg_num  = op[3:0];
   wire logic [2:0] adr_code = op[2:0];

   // address code selector decode, native and compatibility maps
   // both ports always get an address, even when only one latch loads,
   // so an unused port just reads a word that nobody keeps
   logic [3:0] code_dest;
   logic [3:0] code_src;
   always_comb begin
      code_dest = 4'h0;
      code_src  = 4'h0;
      if (!ctx.compat_mode) begin
         case (adr_code)
            3'h0: begin
               // register of the specifier under examination
               code_dest = ctx.spec_one_reg_field;
               code_src  = ctx.spec_one_reg_field;
            end
            3'h1: begin
               // register of the byte after that specifier
               code_dest = ctx.spec_two_reg_field;
               code_src  = ctx.spec_two_reg_field;
            end
            3'h2: begin
               // split form for register to register operations
               code_dest = ctx.spec_two_reg_field;
               code_src  = ctx.spec_one_reg_field;
            end
            3'h3: begin
               // register of the last specifier
               code_dest = ctx.previous_spec_reg;
               code_src  = ctx.previous_spec_reg;
            end
            3'h4: begin
               // wraps from fifteen to zero in four bits
               code_dest = ctx.previous_spec_reg + 4'h1;
               code_src  = ctx.previous_spec_reg + 4'h1;
            end
            3'h5: begin
               // lets microcode step through the general set
               code_dest = ctx.shift_count_reg;
               code_src  = ctx.shift_count_reg;
            end
            3'h6: begin
               // second half of a register pair
               code_dest = ctx.spec_one_reg_field + 4'h1;
               code_src  = ctx.spec_one_reg_field + 4'h1;
            end
            default: begin
               // code seven always names register zero
               code_dest = 4'h0;
               code_src  = 4'h0;
            end
         endcase
      end else begin
         case (adr_code)
            3'h0, 3'h3: begin
               // source field; code three repeats it in this mode
               code_dest = ctx.compat_source_reg;
               code_src  = ctx.compat_source_reg;
            end
            3'h1: begin
               // destination field on both ports
               code_dest = ctx.compat_dest_reg;
               code_src  = ctx.compat_dest_reg;
            end
            3'h2: begin
               // destination port gets destination, source gets source
               code_dest = ctx.compat_dest_reg;
               code_src  = ctx.compat_source_reg;
            end
            3'h4: begin
               // odd register of the pair, an or and not an add
               code_dest = ctx.compat_source_reg | 4'h1;
               code_src  = ctx.compat_source_reg | 4'h1;
            end
            3'h5: begin
               // same stepping path as in native mode
               code_dest = ctx.shift_count_reg;
               code_src  = ctx.shift_count_reg;
            end
            3'h6: begin
               // next register after the source field
               code_dest = ctx.compat_source_reg + 4'h1;
               code_src  = ctx.compat_source_reg + 4'h1;
            end
            default: begin
               // code seven always names register zero
               code_dest = 4'h0;
               code_src  = 4'h0;
            end
         endcase
      end
   end

   // opcode map as decoded below:
   //   00-05 idle; 06 temp latch load and 07 temp write at shift count
   //   08-0F both general latches at the coded address
   //   10-17 destination latch only, registers 0-7 from the low bits
   //   18-1F general write at the coded address
   //   20-2F temp latch load, 30-3F temp write, at the low four bits
   //   40-4F both general latches, 50-5F general write, low four bits
   //   60-6F general latches load while the temp set is written
   //   70-7F temp latch loads while the general set is written
   // the mixed groups read one set and write the other in one cycle;
   // since reads see the old contents, no word crosses between the sets
   // in that cycle, so microcode must never count on an exchange there
   wire logic grp0        = (op_grp == 3'h0);
   wire logic grp1        = (op_grp == 3'h1);
   wire logic temp_ld_sh  = (op == `SPR_OP_TEMP_LOAD_SH);
   wire logic temp_wr_sh  = (op == `SPR_OP_TEMP_WRITE_SH);
   wire logic gen_ld_code = grp0 && op_hi;
   wire logic dest_ld_num = grp1 && !op_hi;
   wire logic gen_wr_code = grp1 && op_hi;
   wire logic gen_ld_num  = (op_grp == 3'h4) || (op_grp == 3'h6);
   wire logic gen_wr_num  = (op_grp == 3'h5) || (op_grp == 3'h7);
   wire logic temp_ld_num = (op_grp == 3'h2) || (op_grp == 3'h7);
   wire logic temp_wr_num = (op_grp == 3'h3) || (op_grp == 3'h6);

   wire logic gen_ld      = gen_ld_code || gen_ld_num;
   wire logic dest_ld     = gen_ld || dest_ld_num;
   wire logic gen_wr      = gen_wr_code || gen_wr_num;
   wire logic temp_ld     = temp_ld_sh || temp_ld_num;
   wire logic temp_wr     = temp_wr_sh || temp_wr_num;

   // addresses; explicit numbers win unless the opcode is a coded form
   // 10-17 reach only registers 0-7, as the group leaves three bits
   wire logic       use_code  = grp0 || (grp1 && op_hi);
   wire logic [3:0] dest_addr = use_code    ? code_dest :
                                dest_ld_num ? {1'b0, adr_code} :
                                              reg_num;
   wire logic [3:0] src_addr  = use_code ? code_src : reg_num;
   // the temp set takes the shift count only in the 00-0F group
   wire logic [3:0] temp_addr = grp0 ? ctx.shift_count_reg :
                                       reg_num;

   // effective general write width
   // a float context overrides both the field and the decoded width, so
   // a double spread over two registers is never written in pieces
   wire spr_dt_t dt_sel  = (uword.data_type_select == SPR_DT_DECODE) ?
                           ctx.decode_dt : uword.data_type_select;
   wire spr_dt_t dt_eff  = ctx.float_ctx ? SPR_DT_LONG : dt_sel;

   // partial writes keep the untouched upper bits of the register
   // this reads the old word in the write cycle, which costs a read path
   // on the destination port but avoids per-byte enables on the array
   wire logic [31:0] gen_old = gen_bank[dest_addr];
   wire logic [31:0] gen_new =
      (dt_eff == SPR_DT_WORD) ? {gen_old[31:16], wr_data[15:0]} :
      (dt_eff == SPR_DT_BYTE) ? {gen_old[31:8],  wr_data[7:0]}  :
                                wr_data;

   // width code for the accelerator copy; no write reports code three,
   // and a decoded width of three is reported as a longword
   wire spr_fw_t fw_code =
      !gen_wr                 ? SPR_FW_NONE :
      (dt_eff == SPR_DT_WORD) ? SPR_FW_WORD :
      (dt_eff == SPR_DT_BYTE) ? SPR_FW_BYTE : SPR_FW_LONG;

   // storage arrays take writes at cycle end; no reset on the banks
   // the banks and the log stay unknown until microcode fills them; a
   // reset of every word would cost a wide tree and buy nothing, since
   // microcode never reads a register it has not written
   always_ff @(posedge pclk) begin
      if (gen_wr)
         gen_bank[dest_addr] <= gen_new;
      if (temp_wr)
         temp_bank[temp_addr] <= wr_data;
      if (uword.log_update)
         undo_mem[log_ptr_reg] <= {uword.log_add,
                                   ctx.constant_mux,
                                   dest_addr};
   end

   // read latches capture the prior bank contents
   // a load and a write of the same word in one cycle give the old word,
   // which is what makes the 60-7F groups safe to use
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dest_port_latch <= 32'h0000_0000;
         src_port_latch  <= 32'h0000_0000;
         temp_read_latch <= 32'h0000_0000;
      end else begin
         if (dest_ld)
            dest_port_latch <= gen_bank[dest_addr];
         if (gen_ld)
            src_port_latch <= gen_bank[src_addr];
         if (temp_ld)
            temp_read_latch <= temp_bank[temp_addr];
      end
   end

   // accelerator notification, one cycle after the write is commanded
   // it lands on the same edge as the bank write, so the copy kept by
   // the accelerator never runs ahead of or behind the general set;
   // the address is sent even when no write is reported
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         float_accelerator <= '{addr: 4'h0, we_code: SPR_FW_NONE};
      else
         float_accelerator <= '{addr: dest_addr, we_code: fw_code};
   end

   // undo log pointer; read direction chosen by control bit
   // an instruction fetch wins over any log update or read in the same
   // cycle: the new instruction must start with an empty log
   // entries are stored at the pointer and the pointer then moves up;
   // a read shows the entry at the pointer and then moves it the way
   // the control bit says, since the walk-back order is left open
   // the pointer wraps after sixteen entries with no overflow flag, so
   // an instruction with more updates than that loses its oldest ones
   wire logic       ptr_down = ctrl_reg[`SPR_CTRL_PTR_DOWN_BIT];
   wire logic [3:0] ptr_step = ptr_down ? (log_ptr_reg - 4'h1) :
                                          (log_ptr_reg + 4'h1);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         log_ptr_reg  <= 4'h0;
         log_empty    <= 1'b1;
         reg_undo_log <= 9'h000;
         pc_low_save  <= 8'h00;
      end else if (uword.instr_fetch) begin
         log_ptr_reg <= 4'h0;
         log_empty   <= 1'b1;
         pc_low_save <= ctx.pc_low;
      end else begin
         if (uword.log_update) begin
            log_ptr_reg <= log_ptr_reg + 4'h1;
            log_empty   <= 1'b0;
         end else if (uword.log_read) begin
            log_ptr_reg <= ptr_step;
         end
         if (uword.log_read)
            reg_undo_log <= undo_mem[log_ptr_reg];
      end
   end

   // apb decode
   // register map: control at 000, status at 004, then the three read
   // latches at 008, 00C and 010; only control can be written, and a
   // write to the other four is dropped with no error
   // any other offset answers with an error and reads zero
   // the latches are shown as they stand, which lets software watch the
   // data path without disturbing it
   wire logic setup_ph  = psel && !penable;
   wire logic access_ok = psel && penable && pready_reg;
   wire logic hit_ctrl  = (paddr == `SPR_CTRL_OFS);
   wire logic hit_stat  = (paddr == `SPR_STATUS_OFS);
   wire logic hit_dl    = (paddr == `SPR_DEST_LATCH_OFS);
   wire logic hit_sl    = (paddr == `SPR_SRC_LATCH_OFS);
   wire logic hit_tl    = (paddr == `SPR_TEMP_LATCH_OFS);
   wire logic hit_any   = hit_ctrl || hit_stat || hit_dl || hit_sl || hit_tl;

   // status word: empty flag, log pointer and the saved pc byte
   // all three are live, so a read shows the state of that cycle
   logic [31:0] status_word;
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[`SPR_STAT_EMPTY_BIT] = log_empty;
      status_word[`SPR_STAT_PTR_LSB +: 4] = log_ptr_reg;
      status_word[`SPR_STAT_PC_LSB +: 8]  = pc_low_save;
   end

   wire logic [31:0] rd_mux =
      hit_ctrl ? ctrl_reg        :
      hit_stat ? status_word     :
      hit_dl   ? dest_port_latch :
      hit_sl   ? src_port_latch  :
      hit_tl   ? temp_read_latch : 32'h0000_0000;

   // data is sampled in setup so the access phase needs no wait state
   // the price is that a read shows the value of the setup cycle, one
   // cycle older than the access; for these slow registers that is fine
   // pready is high for the single access cycle after each setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg    <= `SPR_CTRL_RESET;
         prdata_reg  <= 32'h0000_0000;
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
      end else begin
         pready_reg <= setup_ph;
         if (setup_ph) begin
            prdata_reg  <= pwrite ? 32'h0000_0000 : rd_mux;
            pslverr_reg <= !hit_any;
         end
         if (access_ok && pwrite && hit_ctrl)
            ctrl_reg <= {31'h0000_0000, pwdata[`SPR_CTRL_PTR_DOWN_BIT]};
      end
   end

   assign prdata  = prdata_reg;
   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;

endmodule

// ===== sim/spr_scratchpad_chk.sv
`timescale 1ns/1ps
module spr_scratchpad_chk
   import spr_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire spr_uword_t  uword,
   input wire spr_ctx_t    ctx,
   input wire logic [31:0] dest_port_latch,
   input wire logic [31:0] src_port_latch,
   input wire logic [31:0] temp_read_latch,
   input wire spr_fac_t    float_accelerator,
   input wire logic        log_empty,
   input wire logic [7:0]  pc_low_save
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // opcode classes; general writes are 18-1F, 50-5F and 70-7F
   wire logic [6:0] op = uword.scratchpad_opcode_field;
   wire logic gw = op[6:3] == 4'h3 || op[6:4] == 3'h5 || op[6:4] == 3'h7;
   wire logic [1:0] wc = float_accelerator.we_code;
   wire logic lng = ctx.float_ctx || uword.data_type_select == SPR_DT_LONG;
   wire logic byt = !ctx.float_ctx && uword.data_type_select == SPR_DT_BYTE;
   // a fetch is checked for two effects in the next cycle: flag raised and pc byte captured
   sequence s_fetch_done;
      log_empty && pc_low_save == $past(ctx.pc_low);
   endsequence
   property p_noop;
      op < 7'h06 |=> $stable(dest_port_latch) && $stable(src_port_latch)
         && $stable(temp_read_latch);
   endproperty
   property p_none; !gw |=> wc == SPR_FW_NONE; endproperty
   property p_long; gw && lng |=> wc == SPR_FW_LONG; endproperty
   property p_byte; gw && byt |=> wc == SPR_FW_BYTE; endproperty
   property p_wr_num;
      op[6:4] == 3'h5 |=> float_accelerator.addr == $past(op[3:0]);
   endproperty
   property p_dest_only; op[6:3] == 4'h2 |=> $stable(src_port_latch);
   endproperty
   property p_apart; op[6:5] == 2'h2 |=> $stable(temp_read_latch);
   endproperty
   property p_fetch; uword.instr_fetch |=> s_fetch_done; endproperty
   property p_fill;
      uword.log_update && !uword.instr_fetch |=> !log_empty;
   endproperty
   a_noop: assert property (p_noop)
      else $error("latch moved on idle opcode");
   a_none: assert property (p_none)
      else $error("write code without a general write");
   a_long: assert property (p_long)
      else $error("longword code missing");
   a_byte: assert property (p_byte)
      else $error("byte code missing");
   a_wr_num: assert property (p_wr_num)
      else $error("write address wrong");
   a_dest_only: assert property (p_dest_only)
      else $error("source latch moved");
   a_apart: assert property (p_apart)
      else $error("temp latch moved");
   a_fetch: assert property (p_fetch)
      else $error("fetch effects missing");
   a_fill: assert property (p_fill) else $error("log still empty");
endmodule
bind spr_scratchpad spr_scratchpad_chk u_spr_scratchpad_chk (
   .pclk(pclk), .presetn(presetn), .uword(uword), .ctx(ctx),
   .dest_port_latch(dest_port_latch), .src_port_latch(src_port_latch),
   .temp_read_latch(temp_read_latch),
   .float_accelerator(float_accelerator),
   .log_empty(log_empty), .pc_low_save(pc_low_save));

// ===== sim/spr_useq_model.sv
`timescale 1ns/1ps
// stands in for the microsequencer and decode: fields held between calls
module spr_useq_model
   import spr_pkg::*;
(
   input  wire logic        pclk,
   output spr_uword_t       uword,
   output spr_ctx_t         ctx,
   output logic      [31:0] wr_data
);
   initial begin
      uword = '0;
      ctx = '0;
      wr_data = 32'h0;
   end
   // one microinstruction; 60-7F never used to swap sets
   task automatic issue(input logic [6:0] o, input spr_dt_t t,
                        input logic [3:0] f, input logic [31:0] d);
      @(posedge pclk);
      uword <= {o, t, f};
      wr_data <= d;
   endtask
   // data is meaningless when idle, so it toggles rather than holds
   task automatic idle;
      issue(7'h00, SPR_DT_LONG, 4'h0, ~wr_data);
   endtask
   // decode fields: specifier, previous and mode registers
   task automatic set_ctx(input spr_ctx_t c);
      @(posedge pclk);
      ctx <= c;
   endtask
endmodule

// ===== sim/spr_scratchpad_tb.sv
`timescale 1ns/1ps
`include "spr_regs.svh"
module spr_scratchpad_tb
   import spr_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, log_empty;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, wr_data, dl, sl, tl;
   spr_uword_t  uword;
   spr_ctx_t    ctx, cx;
   spr_fac_t    fa;
   logic [8:0]  undo_out;
   logic [7:0]  pcs;
   int          fails, checked;
   spr_scratchpad u_spr_scratchpad (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .uword(uword), .ctx(ctx), .wr_data(wr_data), .dest_port_latch(dl),
      .src_port_latch(sl), .temp_read_latch(tl), .float_accelerator(fa),
      .reg_undo_log(undo_out), .log_empty(log_empty), .pc_low_save(pcs));
   spr_useq_model u_spr_useq_model (.pclk(pclk), .uword(uword),
      .ctx(ctx), .wr_data(wr_data));
   always #4 pclk = ~pclk;
   task automatic chk(input string n, input logic [39:0] s, e);
      checked++;
      if (s !== e) begin
         fails++;
         $display("Error %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic stop_test;
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // request held until pready is sampled high at an edge
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [32:0] e);
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      do @(posedge pclk); while (pready !== 1'h1);
      if (!w) chk("apb read", {pslverr, prdata}, e);
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic op(input logic [6:0] o, input spr_dt_t t,
                     input logic [3:0] f, input logic [31:0] d);
      u_spr_useq_model.issue(o, t, f, d);
   endtask
   task automatic nw(input logic [6:0] o, input logic [3:0] f);
      op(o, SPR_DT_LONG, f, ~wr_data);
   endtask
   // let the last microword land, then look at settled outputs
   task automatic fin;
      u_spr_useq_model.idle;
      @(negedge pclk);
   endtask
   function automatic logic [31:0] gv(input logic [3:0] n);
      return {28'hA5C3F00, n};
   endfunction
   // unmapped offset is refused
   task automatic t_apb;
      apb(1'h0, `SPR_CTRL_OFS, 32'h0, 33'h0);
      apb(1'h1, `SPR_CTRL_OFS, 32'h1, 33'h0);
      apb(1'h0, `SPR_CTRL_OFS, 32'h0, 33'h1);
      apb(1'h0, 12'h0FC, 32'h0, {1'h1, 32'h0});
      apb(1'h1, `SPR_CTRL_OFS, 32'h0, 33'h0);
   endtask
   task automatic t_fill;
      u_spr_useq_model.set_ctx(cx);
      for (int n = 0; n < 16; n++) op({3'h5, n[3:0]}, SPR_DT_LONG, 4'h0, gv(n));
      nw(7'h4F, 4'h0);
      fin;
      chk("dest", dl, gv(4'hF));
      chk("src", sl, gv(4'hF));
      nw(7'h13, 4'h0);
      fin;
      chk("dest rn", dl, gv(4'h3));
      chk("src kept", sl, gv(4'hF));
   endtask
   // every address code in native then compatibility mode
   task automatic t_acn;
      logic [31:0] md[2] = '{32'h03654772, 32'h09698BB8};
      logic [31:0] ms[2] = '{32'h03654272, 32'h096988B8};
      for (int m = 0; m < 2; m++) begin
         cx.compat_mode = m[0];
         u_spr_useq_model.set_ctx(cx);
         for (int a = 0; a < 8; a++) begin
            nw({4'h1, a[2:0]}, 4'h0);
            fin;
            chk("acn dest", dl, gv(md[m][a*4+:4]));
            chk("acn src", sl, gv(ms[m][a*4+:4]));
         end
      end
      op(7'h19, SPR_DT_LONG, 4'h0, 32'h5A5A0F0F);
      nw(7'h4B, 4'h0);
      fin;
      chk("acn write", dl, 32'h5A5A0F0F);
   endtask
   // byte write to temp still stores the whole word; 60-7F split
   task automatic t_temp;
      op(7'h07, SPR_DT_BYTE, 4'h0, 32'h13579BDF);
      op(7'h39, SPR_DT_LONG, 4'h0, 32'h2468ACE0);
      nw(7'h29, 4'h0);
      fin;
      chk("temp rn", tl, 32'h2468ACE0);
      nw(7'h06, 4'h0);
      fin;
      chk("temp sc", tl, 32'h13579BDF);
      op(7'h69, SPR_DT_LONG, 4'h0, 32'h11112222);
      op(7'h79, SPR_DT_LONG, 4'h0, 32'h33334444);
      fin;
      chk("gen via 69", dl, gv(4'h9));
      chk("temp via 79", tl, 32'h11112222);
      nw(7'h49, 4'h0);
      fin;
      chk("gen by 79", dl, 32'h33334444);
      apb(1'h0, `SPR_TEMP_LATCH_OFS, 32'h0, 33'h011112222);
   endtask
   // partial writes keep the upper bits unless float context
   task automatic t_width;
      spr_dt_t t[4] = '{SPR_DT_WORD, SPR_DT_BYTE, SPR_DT_DECODE, SPR_DT_BYTE};
      spr_fw_t w[4] = '{SPR_FW_WORD, SPR_FW_BYTE, SPR_FW_BYTE, SPR_FW_LONG};
      logic [31:0] ex[4] = '{32'hFFFF1256, 32'hFFFFFF56, 32'hFFFFFF56,
                             32'h00001256};
      for (int i = 0; i < 4; i++) begin
         cx.float_ctx = (i == 3);
         u_spr_useq_model.set_ctx(cx);
         op(7'h5C, SPR_DT_LONG, 4'h0, 32'hFFFFFFFF);
         op(7'h5C, t[i], 4'h0, 32'h00001256);
         fin;
         chk("accel", fa, {4'hC, w[i]});
         nw(7'h4C, 4'h0);
         fin;
         chk("width", sl, ex[i]);
      end
   endtask
   // undo log: fill, refetch, replay upward, then one step down
   task automatic t_log;
      nw(7'h00, 4'h1);
      op(7'h53, SPR_DT_LONG, 4'hC, 32'h0);
      op(7'h55, SPR_DT_LONG, 4'h8, 32'h0);
      fin;
      chk("pc save", pcs, 8'h3C);
      chk("empty", log_empty, 1'h0);
      nw(7'h00, 4'h1);
      nw(7'h00, 4'h2);
      fin;
      chk("log 0", undo_out, 9'h123);
      nw(7'h00, 4'h2);
      fin;
      chk("log 1", undo_out, 9'h025);
      apb(1'h0, `SPR_STATUS_OFS, 32'h0, 33'h000003C21);
      apb(1'h1, `SPR_CTRL_OFS, 32'h1, 33'h0);
      nw(7'h00, 4'h2);
      fin;
      apb(1'h0, `SPR_STATUS_OFS, 32'h0, 33'h000003C11);
   endtask
   initial begin
      {pclk, presetn, psel, penable, pwrite} = 5'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      {fails, checked} = 64'h0;
      cx = {2'h0, SPR_DT_BYTE, 28'h6274_8B2, 8'h3C};
      repeat (5) @(posedge pclk);
      presetn <= 1'h1;
      t_apb;
      t_fill;
      t_acn;
      t_temp;
      t_width;
      t_log;
      stop_test;
   end
   // cut a hang short well beyond the expected run length
   initial begin
      repeat (4000) @(posedge pclk);
      fails++;
      stop_test;
   end
endmodule
